// file: cgu_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cgu_top import cgu_pkg::*; (
	// Clock, reset, enable
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	// AXI4-Lite write address and data
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [DATA_W-1:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	// AXI4-Lite write response
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	// AXI4-Lite read
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	// Asynchronous sources
	input wire logic [5:0] TABLE_INPUT_PINS,
	input wire logic EVENT_LINE_A,
	input wire logic EVENT_LINE_B,
	input wire logic COMPARATOR_IN,
	input wire logic TIMER_IN,
	// Outputs
	output logic [NTAB-1:0] TABLE_OUTPUT_PIN
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [RAW_W-1:0] sy1;
		logic [RAW_W-1:0] sy2;
		logic ge;
		logic [3:0] sequential_function_select;
		logic [NTAB-1:0][REG_W-1:0] ca;
		logic [NTAB-1:0][REG_W-1:0] cb;
		logic [NTAB-1:0][REG_W-1:0] cc;
		logic [NTAB-1:0][REG_W-1:0] tr;
		logic [NTAB-1:0] in2_prev;
		logic d0;
		logic [NTAB-1:0] pin;
		logic aw_got;
		logic w_got;
		logic [3:0] aw_idx;
		logic [REG_W-1:0] wdat;
		logic wstb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
	} cgu_top_st_t;

	cgu_top_st_t s_q, s_d;
	logic seq_q;
	logic [NTAB-1:0][2:0] raw;
	logic [NTAB-1:0][2:0] lk_in;
	logic [NTAB-1:0] ten;
	logic [NTAB-1:0] tick;
	logic [NTAB-1:0] res;
	logic [NTAB-1:0] dir;

	cgu_stage_if st[NTAB] ();

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic reg_mapped(input logic [3:0] idx);
		reg_mapped = (idx == IDX_GLOBAL) || (idx == IDX_SEQ) || (idx == IDX_STATUS) ||
			((idx >= IDX_CA0) && (idx < IDX_CA0 + (IDX_STRIDE << 1)));
	endfunction : reg_mapped

	function automatic logic src_mux(input logic [3:0] sel, input logic fb, input logic link,
		input logic pin, input logic [RAW_W-1:0] sy);
		case (sel)
			SRC_FEEDBACK: src_mux = fb;
			SRC_LINK: src_mux = link;
			SRC_EVENT_A: src_mux = sy[RAW_EVA];
			SRC_EVENT_B: src_mux = sy[RAW_EVB];
			SRC_IO: src_mux = pin;
			SRC_COMPARATOR: src_mux = sy[RAW_CMP];
			SRC_TIMER: src_mux = sy[RAW_TMR];
			default: src_mux = 1'h0;
		endcase
	endfunction : src_mux

	// ----------------------------------------------------------------
	// Input selection and ticks
	// ----------------------------------------------------------------
	always_comb begin
		raw = '0;
		lk_in = '0;
		for (int n = 0; n < NTAB; n++) begin
			// Table 1 link reads a registered copy of table 0 to break the loop
			raw[n][0] = src_mux(s_q.cb[n][SEL0_LO +: 4], seq_q, (n == 0) ? dir[1] : s_q.d0,
				s_q.sy2[n*3], s_q.sy2);
			raw[n][1] = src_mux(s_q.cb[n][SEL1_LO +: 4], seq_q, (n == 0) ? dir[1] : s_q.d0,
				s_q.sy2[n*3+1], s_q.sy2);
			raw[n][2] = src_mux(s_q.cc[n][SEL2_LO +: 4], seq_q, (n == 0) ? dir[1] : s_q.d0,
				s_q.sy2[n*3+2], s_q.sy2);
			lk_in[n] = {raw[n][2] & ~s_q.ca[n][CA_CLOCK_SOURCE_SELECT], raw[n][1:0]};
		end
	end

	genvar g;
	generate
		for (g = 0; g < NTAB; g++) begin : g_tab
			assign ten[g] = s_q.ge & s_q.ca[g][CA_EN];
			assign tick[g] = s_q.ca[g][CA_CLOCK_SOURCE_SELECT] ? (raw[g][2] & ~s_q.in2_prev[g]) : 1'h1;
			assign st[g].en = ten[g];
			assign st[g].tick = tick[g];
			assign st[g].ins = lk_in[g];
			assign st[g].truth = s_q.tr[g];
			assign st[g].fsel = s_q.ca[g][CA_FSEL_LO +: 2];
			assign st[g].edge_en = s_q.ca[g][CA_EDGE];
			assign res[g] = st[g].result;
			assign dir[g] = st[g].direct;

			cgu_stage u_stage (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.ce(CE),
				.s(st[g].stage)
			);
		end
	endgenerate

	cgu_seq u_seq (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.ce(CE),
		.tick(tick[0]),
		.en(ten[0]),
		.mode(s_q.sequential_function_select),
		.even_in(res[0]),
		.odd_in(res[1]),
		.q(seq_q)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] ridx;
		s_d = s_q;
		ridx = S_AXI_ARADDR[5:2];
		s_d.sy1 = {TIMER_IN, COMPARATOR_IN, EVENT_LINE_B, EVENT_LINE_A, TABLE_INPUT_PINS};
		s_d.sy2 = s_q.sy1;
		s_d.d0 = dir[0];
		for (int n = 0; n < NTAB; n++) begin
			s_d.in2_prev[n] = raw[n][2];
			if (n == 0 && s_q.sequential_function_select != SEQ_OFF) begin
				s_d.pin[n] = ten[n] & s_q.ca[n][CA_OUTEN] & seq_q;
			end else begin
				s_d.pin[n] = ten[n] & s_q.ca[n][CA_OUTEN] & res[n];
			end
		end
		// Write path: address and data land in either order
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'h0;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'h0;
			s_d.w_got = 1'h0;
			s_d.bvalid = 1'h1;
			s_d.bresp = reg_mapped(s_q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
			if (s_q.wstb) begin
				if (s_q.aw_idx == IDX_GLOBAL) begin
					s_d.ge = s_q.wdat[GE_BIT];
				end
				if (s_q.aw_idx == IDX_SEQ && !s_q.ca[0][CA_EN]) begin
					s_d.sequential_function_select = s_q.wdat[3:0];
				end
				for (int n = 0; n < NTAB; n++) begin
					if (s_q.aw_idx == IDX_CA0 + 4'(n) * IDX_STRIDE) begin
						if (!s_q.ca[n][CA_EN]) begin
							s_d.ca[n] = s_q.wdat & CA_WMASK;
						end else begin
							s_d.ca[n][CA_EN] = s_q.wdat[CA_EN];
						end
					end
					if (s_q.aw_idx == IDX_CB0 + 4'(n) * IDX_STRIDE && !s_q.ca[n][CA_EN]) begin
						s_d.cb[n] = s_q.wdat;
					end
					if (s_q.aw_idx == IDX_CC0 + 4'(n) * IDX_STRIDE && !s_q.ca[n][CA_EN]) begin
						s_d.cc[n] = s_q.wdat;
					end
					if (s_q.aw_idx == IDX_TR0 + 4'(n) * IDX_STRIDE) begin
						s_d.tr[n] = s_q.wdat;
					end
				end
			end
		end
		if (S_AXI_AWVALID && s_q.awready) begin
			s_d.aw_got = 1'h1;
			s_d.aw_idx = S_AXI_AWADDR[5:2];
		end
		if (S_AXI_WVALID && s_q.wready) begin
			s_d.w_got = 1'h1;
			s_d.wdat = S_AXI_WDATA[REG_W-1:0];
			s_d.wstb = S_AXI_WSTRB[0];
		end
		s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
		s_d.wready = ~s_d.w_got & ~s_d.bvalid;
		// Read path: one outstanding read
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'h0;
		end
		if (S_AXI_ARVALID && s_q.arready) begin
			s_d.rvalid = 1'h1;
			s_d.rdata = '0;
			s_d.rresp = reg_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
			if (ridx == IDX_GLOBAL) begin
				s_d.rdata[GE_BIT] = s_q.ge;
			end
			if (ridx == IDX_SEQ) begin
				s_d.rdata[3:0] = s_q.sequential_function_select;
			end
			if (ridx == IDX_STATUS) begin
				s_d.rdata[ST_RES0] = res[0];
				s_d.rdata[ST_RES1] = res[1];
				s_d.rdata[ST_SEQ] = seq_q;
				s_d.rdata[ST_GE] = s_q.ge;
			end
			for (int n = 0; n < NTAB; n++) begin
				if (ridx == IDX_CA0 + 4'(n) * IDX_STRIDE) begin
					s_d.rdata[REG_W-1:0] = s_q.ca[n];
				end
				if (ridx == IDX_CB0 + 4'(n) * IDX_STRIDE) begin
					s_d.rdata[REG_W-1:0] = s_q.cb[n];
				end
				if (ridx == IDX_CC0 + 4'(n) * IDX_STRIDE) begin
					s_d.rdata[REG_W-1:0] = s_q.cc[n];
				end
				if (ridx == IDX_TR0 + 4'(n) * IDX_STRIDE) begin
					s_d.rdata[REG_W-1:0] = s_q.tr[n];
				end
			end
		end
		s_d.arready = ~s_d.rvalid;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.awready <= 1'h1;
			s_q.wready <= 1'h1;
			s_q.arready <= 1'h1;
		end else if (CE) begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign S_AXI_AWREADY = s_q.awready;
	assign S_AXI_WREADY = s_q.wready;
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_ARREADY = s_q.arready;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RDATA = s_q.rdata;
	assign S_AXI_RRESP = s_q.rresp;
	assign TABLE_OUTPUT_PIN = s_q.pin;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic wr_go;
	assign wr_go = s_q.aw_got & s_q.w_got & ~s_q.bvalid & s_q.wstb & CE;

	AST_SEQ_PROTECT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(wr_go && s_q.aw_idx == IDX_SEQ && s_q.ca[0][CA_EN]) |=> $stable(s_q.sequential_function_select))
		else $error("sequential select changed while table 0 enabled");

	AST_CTRL_PROTECT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(wr_go && s_q.aw_idx == IDX_CB0 && s_q.ca[0][CA_EN]) |=> $stable(s_q.cb[0]))
		else $error("control B changed while table enabled");

	AST_EN_CLEAR_IGNORE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(wr_go && s_q.aw_idx == IDX_CA0 && s_q.ca[0][CA_EN] && !s_q.wdat[CA_EN])
		|=> !s_q.ca[0][CA_EN] && s_q.ca[0][CA_FSEL_LO +: 2] == $past(s_q.ca[0][CA_FSEL_LO +: 2]))
		else $error("protected bits taken on disable write");

	AST_GLOBAL_EN: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(wr_go && s_q.aw_idx == IDX_GLOBAL) |=> s_q.ge == $past(s_q.wdat[GE_BIT]))
		else $error("global enable did not follow write");

	AST_LOOKUP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(CE && ten[1] && s_q.ca[1][CA_OUTEN] && s_q.ca[1][CA_FSEL_LO +: 2] == FILT_OFF &&
		!s_q.ca[1][CA_EDGE]) |=> TABLE_OUTPUT_PIN[1] == $past(s_q.tr[1][lk_in[1]]))
		else $error("table 1 output does not match truth pattern");

	AST_MASK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(s_q.cb[0][SEL0_LO +: 4] == SRC_MASK) |-> !lk_in[0][0])
		else $error("masked input not low");

	AST_FEEDBACK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(s_q.cb[1][SEL1_LO +: 4] == SRC_FEEDBACK) |-> lk_in[1][1] == seq_q)
		else $error("feedback input does not follow sequential output");

	AST_CLOCK_SOURCE_SELECT_MASK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_q.ca[0][CA_CLOCK_SOURCE_SELECT] |-> !lk_in[0][2])
		else $error("input 2 not masked under clock select");

	AST_SEQ_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(CE && !ten[0]) ##1 CE |-> !seq_q ##1 !seq_q)
		else $error("sequential element not held clear after disable");

	AST_RESP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(CE && s_q.aw_got && s_q.w_got && !s_q.bvalid) |=> S_AXI_BVALID)
		else $error("write response missing");
endmodule : cgu_top
`default_nettype wire

// file: cgu_pkg.sv
package cgu_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NTAB = 2;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int RAW_W = 10;
	// ----------------------------------------------------------------
	// Register word indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_GLOBAL = 4'h0;
	localparam logic [3:0] IDX_SEQ = 4'h1;
	localparam logic [3:0] IDX_CA0 = 4'h5;
	localparam logic [3:0] IDX_CB0 = 4'h6;
	localparam logic [3:0] IDX_CC0 = 4'h7;
	localparam logic [3:0] IDX_TR0 = 4'h8;
	localparam logic [3:0] IDX_STRIDE = 4'h4;
	localparam logic [3:0] IDX_STATUS = 4'hD;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GE_BIT = 0;
	localparam int CA_EN = 0;
	localparam int CA_OUTEN = 3;
	localparam int CA_FSEL_LO = 4;
	localparam int CA_CLOCK_SOURCE_SELECT = 6;
	localparam int CA_EDGE = 7;
	localparam logic [7:0] CA_WMASK = 8'hF9;
	localparam int SEL0_LO = 0;
	localparam int SEL1_LO = 4;
	localparam int SEL2_LO = 0;
	localparam int ST_RES0 = 0;
	localparam int ST_RES1 = 1;
	localparam int ST_SEQ = 2;
	localparam int ST_GE = 3;
	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [3:0] SEQ_OFF = 4'h0;
	localparam logic [3:0] SEQ_DFF = 4'h1;
	localparam logic [3:0] SEQ_JK = 4'h2;
	localparam logic [3:0] SEQ_DLATCH = 4'h3;
	localparam logic [3:0] SEQ_RS = 4'h4;
	localparam logic [3:0] SRC_MASK = 4'h0;
	localparam logic [3:0] SRC_FEEDBACK = 4'h1;
	localparam logic [3:0] SRC_LINK = 4'h2;
	localparam logic [3:0] SRC_EVENT_A = 4'h3;
	localparam logic [3:0] SRC_EVENT_B = 4'h4;
	localparam logic [3:0] SRC_IO = 4'h5;
	localparam logic [3:0] SRC_COMPARATOR = 4'h6;
	localparam logic [3:0] SRC_TIMER = 4'h7;
	localparam logic [1:0] FILT_OFF = 2'h0;
	localparam logic [1:0] FILT_SYNC = 2'h1;
	localparam logic [1:0] FILT_GLITCH = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Raw input bit positions in the synchroniser
	localparam int RAW_EVA = 6;
	localparam int RAW_EVB = 7;
	localparam int RAW_CMP = 8;
	localparam int RAW_TMR = 9;
endpackage : cgu_pkg

// file: cgu_stage_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cgu_stage_if;
	logic en;
	logic tick;
	logic [2:0] ins;
	logic [7:0] truth;
	logic [1:0] fsel;
	logic edge_en;
	logic direct;
	logic result;
	modport ctrl(output en, tick, ins, truth, fsel, edge_en, input direct, result);
	modport stage(input en, tick, ins, truth, fsel, edge_en, output direct, result);
endinterface : cgu_stage_if
`default_nettype wire

// file: cgu_stage.sv
`timescale 1ns/10ps
`default_nettype none
module cgu_stage import cgu_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control side
	cgu_stage_if.stage s
);
	typedef struct packed {
		logic [2:0] sh;
		logic flt;
		logic prev;
		logic pulse;
	} cgu_stage_st_t;

	cgu_stage_st_t s_q, s_d;
	logic filt_out;

	assign s.direct = s.en & s.truth[s.ins];
	assign filt_out = (s.fsel == FILT_SYNC) ? s_q.sh[1] : s_q.flt;
	assign s.result = s.edge_en ? s_q.pulse : ((s.fsel == FILT_OFF) ? s.direct : filt_out);

	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'h0;
		if (!s.en) begin
			s_d = '0;
		end else if (s.tick) begin
			// Glitch mode waits for two equal samples: four ticks in all
			s_d.sh = {s_q.sh[1:0], s.direct};
			if (s_q.sh[1] == s_q.sh[2]) begin
				s_d.flt = s_q.sh[2];
			end
			s_d.prev = (s.fsel == FILT_OFF) ? s.direct : filt_out;
			s_d.pulse = s_d.prev & ~s_q.prev;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
endmodule : cgu_stage
`default_nettype wire

// file: cgu_seq.sv
`timescale 1ns/10ps
`default_nettype none
module cgu_seq import cgu_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control
	input wire logic tick,
	input wire logic en,
	input wire logic [3:0] mode,
	// Data from the table pair
	input wire logic even_in,
	input wire logic odd_in,
	// Result
	output logic q
);
	typedef struct packed {
		logic q;
		logic hold;
	} cgu_seq_st_t;

	cgu_seq_st_t s_q, s_d;

	// Disable clears the output at once, not at the next edge
	assign q = s_q.q & en;

	always_comb begin
		s_d = s_q;
		s_d.hold = ~en;
		if (!en || s_q.hold) begin
			s_d.q = 1'h0;
		end else if (tick) begin
			case (mode)
				// Latch is sampled on the selected clock like the flip-flop
				SEQ_DFF, SEQ_DLATCH: begin
					if (odd_in) begin
						s_d.q = even_in;
					end
				end
				SEQ_JK: begin
					case ({even_in, odd_in})
						2'h1: s_d.q = 1'h0;
						2'h2: s_d.q = 1'h1;
						2'h3: s_d.q = ~s_q.q;
						default: s_d.q = s_q.q;
					endcase
				end
				SEQ_RS: begin
					// Both high is forbidden: hold rather than guess
					if (even_in && !odd_in) begin
						s_d.q = 1'h1;
					end else if (odd_in && !even_in) begin
						s_d.q = 1'h0;
					end
				end
				default: s_d.q = 1'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
endmodule : cgu_seq
`default_nettype wire

// file: cgu_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module cgu_far_model (
	// Clock
	input wire logic clk,
	// Levels asked for by the bench
	input wire logic [9:0] want,
	// Lines into the block
	output logic [5:0] pins,
	output logic ev_a,
	output logic ev_b,
	output logic cmp,
	output logic tmr
);
	// ----------------------------------------------------------------
	// Line drivers
	// ----------------------------------------------------------------
	// Lines move only after an edge, as pad and event logic would
	logic [9:0] lvl = 10'h000;
	always @(posedge clk) begin
		lvl <= want;
	end
	assign pins = lvl[5:0];
	// Event routing is fixed here, so it is ready before any selection
	assign ev_a = lvl[6];
	assign ev_b = lvl[7];
	assign cmp = lvl[8];
	assign tmr = lvl[9];
endmodule : cgu_far_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top import cgu_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic [5:0] aw_a = 6'h00, ar_a = 6'h00;
	logic [31:0] w_d = 32'h0, rdat, r_d;
	logic [9:0] want = 10'h000;
	logic [1:0] resp, b_rs, r_rs;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, eva, evb, cmp, tmr;
	logic [5:0] pins;
	logic [NTAB-1:0] outp;
	logic [7:0] tt = 8'hB4;
	logic [3:0] codes [5] = '{SRC_EVENT_A, SRC_EVENT_B, SRC_COMPARATOR, SRC_TIMER, SRC_IO};
	int bits [5] = '{RAW_EVA, RAW_EVB, RAW_CMP, RAW_TMR, 0};
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	always #50 clk = ~clk;
	cgu_far_model far_u (.clk(clk), .want(want), .pins(pins), .ev_a(eva), .ev_b(evb),
		.cmp(cmp), .tmr(tmr));
	cgu_top dut_u (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce),
		.S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy), .S_AXI_AWADDR(aw_a),
		.S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF),
		.S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_BRESP(b_rs),
		.S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_ARADDR(ar_a),
		.S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_rs),
		.TABLE_INPUT_PINS(pins), .EVENT_LINE_A(eva), .EVENT_LINE_B(evb),
		.COMPARATOR_IN(cmp), .TIMER_IN(tmr), .TABLE_OUTPUT_PIN(outp));
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		logic done;
		done = 1'b0;
		@(posedge clk);
		aw_v <= 1'b1;
		w_v <= 1'b1;
		aw_a <= {idx, 2'b00};
		w_d <= {24'h0, d};
		b_r <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (aw_v && aw_rdy) aw_v <= 1'b0;
			if (w_v && w_rdy) w_v <= 1'b0;
			if (b_v) begin
				resp = b_rs;
				done = 1'b1;
			end
		end
		b_r <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] idx);
		logic done;
		done = 1'b0;
		@(posedge clk);
		ar_v <= 1'b1;
		ar_a <= {idx, 2'b00};
		r_r <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (ar_v && ar_rdy) ar_v <= 1'b0;
			if (r_v) begin
				rdat = r_d;
				resp = r_rs;
				done = 1'b1;
			end
		end
		r_r <= 1'b0;
	endtask : rd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
		rd(idx);
		chk(rdat, {24'h0, exp});
		chk({30'h0, resp}, {30'h0, RESP_OKAY});
	endtask : rchk
	task automatic pchk(input logic t, input logic e);
		chk({31'h0, outp[t]}, {31'h0, e});
	endtask : pchk
	// Pin to output takes a few cycles through the synchronisers
	task automatic settle;
		repeat (6) @(posedge clk);
	endtask : settle
	task automatic cfg(input logic t, input logic [7:0] a, b, c, tr);
		logic [3:0] base;
		base = t ? IDX_CA0 + IDX_STRIDE : IDX_CA0;
		wr(base, 8'h00);
		wr(base + 4'h1, b);
		wr(base + 4'h2, c);
		wr(base + 4'h3, tr);
		wr(base, a);
	endtask : cfg
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up();
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk(IDX_GLOBAL, 8'h00);
		rchk(IDX_SEQ, 8'h00);
		rchk(IDX_CA0, 8'h00);
		rd(4'h2);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(4'h3, 8'hFF);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		$display("test done: reset values");
		wr(IDX_GLOBAL, 8'h01);
		cfg(1'b0, 8'h09, 8'h55, 8'h05, tt);
		for (int v = 0; v < 8; v++) begin
			want <= {7'h0, v[2:0]};
			settle();
			pchk(1'b0, tt[v]);
		end
		$display("test done: lookup");
		wr(IDX_CB0, 8'h00);
		rchk(IDX_CB0, 8'h55);
		// Clock select rides on a disabling write, so it must be dropped
		wr(IDX_CA0, 8'h40);
		rchk(IDX_CA0, 8'h08);
		pchk(1'b0, 1'b0);
		cfg(1'b0, 8'h09, 8'h00, 8'h00, 8'h01);
		want <= 10'h3FF;
		settle();
		pchk(1'b0, 1'b1);
		wr(IDX_TR0, 8'h02);
		settle();
		pchk(1'b0, 1'b0);
		$display("test done: protection and mask");
		for (int k = 0; k < 5; k++) begin
			cfg(1'b0, 8'h09, {4'h0, codes[k]}, 8'h00, 8'hAA);
			want <= 10'h001 << bits[k];
			settle();
			pchk(1'b0, 1'b1);
			want <= ~(10'h001 << bits[k]);
			settle();
			pchk(1'b0, 1'b0);
		end
		cfg(1'b1, 8'h09, 8'h00, 8'h00, 8'h01);
		cfg(1'b0, 8'h09, {4'h0, SRC_LINK}, 8'h00, 8'hAA);
		settle();
		pchk(1'b0, 1'b1);
		wr(IDX_TR0 + IDX_STRIDE, 8'h00);
		settle();
		pchk(1'b0, 1'b0);
		$display("test done: sources");
		wr(IDX_TR0 + IDX_STRIDE, 8'h01);
		wr(IDX_CA0, 8'h00);
		wr(IDX_SEQ, {4'h0, SEQ_DFF});
		cfg(1'b0, 8'h09, 8'h05, 8'h00, 8'hAA);
		want <= 10'h001;
		settle();
		pchk(1'b0, 1'b1);
		want <= 10'h000;
		settle();
		pchk(1'b0, 1'b0);
		want <= 10'h001;
		settle();
		wr(IDX_SEQ, {4'h0, SEQ_JK});
		rchk(IDX_SEQ, {4'h0, SEQ_DFF});
		wr(IDX_CA0, 8'h08);
		rchk(IDX_STATUS, 8'h0A);
		wr(IDX_SEQ, {4'h0, SEQ_JK});
		rchk(IDX_SEQ, {4'h0, SEQ_JK});
		// K comes from table 1 reading the sequential output back
		cfg(1'b1, 8'h09, 8'h10, 8'h00, 8'h01);
		wr(IDX_CA0, 8'h09);
		settle();
		pchk(1'b0, 1'b1);
		want <= 10'h000;
		settle();
		pchk(1'b0, 1'b1);
		wr(IDX_TR0 + IDX_STRIDE, 8'h04);
		settle();
		pchk(1'b0, 1'b0);
		wr(IDX_CA0, 8'h08);
		$display("test done: sequential");
		wr(IDX_SEQ, {4'h0, SEQ_OFF});
		want <= 10'h000;
		cfg(1'b1, 8'h99, 8'h05, 8'h00, 8'hAA);
		settle();
		want <= 10'h008;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (outp[1] === 1'b1) n++;
		end
		chk(n, 1);
		$display("test done: edge");
		cfg(1'b0, 8'h29, 8'h05, 8'h00, 8'hAA);
		want <= 10'h001;
		n = 0;
		// Glitch-filtered path shows the pin at edge 9
		for (int i = 1; i <= 20; i++) begin
			@(posedge clk);
			if (n == 0 && outp[0] === 1'b1) n = i;
		end
		chk({31'h0, n >= 7 && n <= 10}, 32'h1);
		ce <= 1'b0;
		want <= 10'h000;
		settle();
		pchk(1'b0, 1'b1);
		ce <= 1'b1;
		settle();
		settle();
		pchk(1'b0, 1'b0);
		wr(IDX_CA0, 8'h00);
		settle();
		wr(IDX_CA0, 8'h29);
		@(posedge clk);
		pchk(1'b0, 1'b0);
		$display("test done: filter");
		cfg(1'b0, 8'h09, 8'h00, 8'h00, 8'h01);
		settle();
		pchk(1'b0, 1'b1);
		wr(IDX_GLOBAL, 8'h00);
		settle();
		pchk(1'b0, 1'b0);
		$display("test done: global enable");
		// Sync filter ticks only on rising input 2, which is masked in the lookup
		cfg(1'b0, 8'h59, 8'h05, 8'h05, 8'h0A);
		wr(IDX_GLOBAL, 8'h01);
		want <= 10'h001;
		settle();
		pchk(1'b0, 1'b0);
		want <= 10'h005;
		settle();
		want <= 10'h001;
		settle();
		pchk(1'b0, 1'b0);
		want <= 10'h005;
		settle();
		pchk(1'b0, 1'b1);
		$display("test done: clock select");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
